// file: hw/mfm_top.sv
// Fault coordination for eight channels: zone fault lines, input enable, alert,
// power good and trim DAC scaling. Assumes one 50 MHz clock; channel fault,
// warning and good inputs come from supervisors on that clock.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ns
module mfm_top
   import mfm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   input  wire logic [7:0]  ov_fault_i,
   input  wire logic [7:0]  uv_fault_i,
   input  wire logic [7:0]  warn_i,
   input  wire logic [7:0]  chan_good_i,
   input  wire logic        control_i,
   input  wire logic        bias_ok_i,
   input  wire logic        watchdog_reset_input_n_i,
   input  wire logic [7:0]  zone_fault_line_i,
   output logic [7:0]       zone_fault_line_o,
   output logic [7:0]       zone_fault_line_oe_o,
   output logic [7:0]       chan_enable_o,
   output logic [7:0]       chan_restart_o,
   output logic             input_enable_o,
   output logic             alert_line_n_o,
   output logic             power_good_output_o,
   output logic [9:0]       trim_dac_code_o,
   output logic [11:0]      trim_dac_output_mv_o,
   output logic             dac_full_scale_range_o,
   output logic             share_sync_en_o
);

   ////////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      logic [3:0]  ctrl;
      logic [7:0]  ov_act;
      logic [7:0]  uv_act;
      logic [31:0] prop;
      logic [31:0] resp;
      logic [31:0] amask;
      logic [7:0]  pg_map;
      logic [9:0]  dac_code;
      logic [7:0]  run;
      logic [7:0]  faulted;
      logic [31:0] status;
      logic        vin_low;
      logic [7:0]  line_down;
      logic [7:0]  restart;
      logic [7:0]  chan_en;
      logic [7:0]  line_oe;
      logic        alert_n;
      logic        pg;
      logic [11:0] dac_mv;
      logic [9:0]  dac_pin;
      logic        ctl_prev;
      logic        bias_prev;
      logic [15:0] wd_cnt;
   } mfm_state_t;

   localparam mfm_state_t RST = '{
      ctrl: 4'h0, ov_act: 8'h00, uv_act: 8'h00, prop: RST_PROP, resp: RST_RESP,
      amask: RST_AMASK, pg_map: 8'h00, dac_code: 10'h000, run: 8'h00,
      faulted: 8'h00, status: 32'h0000_0000, vin_low: 1'b0, line_down: 8'h00,
      restart: 8'h00, chan_en: 8'h00, line_oe: 8'h00, alert_n: 1'b1, pg: 1'b1,
      dac_mv: 12'h000, dac_pin: 10'h000, ctl_prev: 1'b1, bias_prev: 1'b1, wd_cnt: 16'h0000};

   mfm_state_t  s, next_s;
   mfm_regreq_t req;
   logic [31:0] rdata;
   logic [7:0]  line_lvl;
   logic        ctl_lvl, bias_lvl, wd_lvl;
   logic        wd_hit;

   // Zone of a channel; channels 0..3 sit in zone 0, 4..7 in zone 1
   function automatic logic [3:0] zone_low(input logic [7:0] lvl, input int ch);
      zone_low = (ch < int'(ZONE_CH)) ? ~lvl[3:0] : ~lvl[7:4];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   mfm_ahb_if u_bus (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .hsel_i      (hsel_i),
      .haddr_i     (haddr_i),
      .htrans_i    (htrans_i),
      .hwrite_i    (hwrite_i),
      .hsize_i     (hsize_i),
      .hwdata_i    (hwdata_i),
      .hready_i    (hready_i),
      .hrdata_o    (hrdata_o),
      .hreadyout_o (hreadyout_o),
      .hresp_o     (hresp_o),
      .req_o       (req),
      .rdata_i     (rdata)
   );

   // Own pulls are sensed back through the pin so every channel sees them
   for (genvar i = 0; i < 8; i++) begin : g_line
      mfm_deglitch #(.CYCLES(FAULT_DEGLITCH_CYC)) u_dg (
         .clk_i     (clk_i),
         .reset_n_i (reset_n_i),
         .pin_i     (zone_fault_line_i[i]),
         .level_o   (line_lvl[i])
      );
   end

   mfm_deglitch #(.CYCLES(PIN_FILTER_CYC)) u_ctl (
      .clk_i (clk_i), .reset_n_i (reset_n_i), .pin_i (control_i), .level_o (ctl_lvl)
   );
   mfm_deglitch #(.CYCLES(PIN_FILTER_CYC)) u_bias (
      .clk_i (clk_i), .reset_n_i (reset_n_i), .pin_i (bias_ok_i), .level_o (bias_lvl)
   );
   mfm_deglitch #(.CYCLES(PIN_FILTER_CYC)) u_wd (
      .clk_i (clk_i), .reset_n_i (reset_n_i), .pin_i (watchdog_reset_input_n_i),
      .level_o (wd_lvl)
   );

   assign wd_hit = s.wd_cnt == 16'(RESET_PULSE_MIN_CYC);

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      logic        on_cmd;
      logic        clr_latch;
      logic        clr_status;
      logic [7:0]  trip;
      logic [21:0] prod;
      on_cmd = 1'b0;
      clr_latch = 1'b0;
      clr_status = 1'b0;
      trip = 8'h00;
      prod = 22'h000000;
      next_s = s;
      next_s.ctl_prev = ctl_lvl;
      next_s.bias_prev = bias_lvl;

      if (req.wr) begin
         unique case (req.addr)
            OFS_CTRL: begin
               next_s.ctrl = {req.wdata[CTRL_SHARE_EN], 1'b0, req.wdata[CTRL_DAC_HI],
                              req.wdata[CTRL_DAC_POL]};
               clr_status = req.wdata[CTRL_CLR_FAULT];
            end
            OFS_VINEN: {next_s.uv_act, next_s.ov_act} = req.wdata[15:0];
            OFS_PROP:  next_s.prop = req.wdata;
            OFS_RESP:  next_s.resp = req.wdata;
            OFS_AMASK: next_s.amask = req.wdata;
            OFS_PGMAP: next_s.pg_map = req.wdata[7:0];
            OFS_DAC:   next_s.dac_code = req.wdata[9:0];
            OFS_OPER: begin
               next_s.run = req.wdata[7:0];
               clr_latch = 1'b1;
               on_cmd = |req.wdata[7:0];
            end
            default: ;
         endcase
      end

      // Control toggle, bias return also clear latches; control rise is an on command
      if (ctl_lvl != s.ctl_prev || (bias_lvl && !s.bias_prev)) begin
         clr_latch = 1'b1;
      end
      if (ctl_lvl && !s.ctl_prev) begin
         on_cmd = 1'b1;
      end

      if (clr_latch) begin
         next_s.faulted = 8'h00;
      end
      next_s.faulted = next_s.faulted | ov_fault_i | uv_fault_i;

      // The on command releases the pull; a same-cycle fault keeps it low
      if (on_cmd) begin
         next_s.vin_low = 1'b0;
      end
      if (|((ov_fault_i & s.ov_act) | (uv_fault_i & s.uv_act))) begin
         next_s.vin_low = 1'b1;
      end

      for (int ch = 0; ch < int'(NUM_CH); ch++) begin
         next_s.line_down[ch] = |(s.resp[ch*4 +: 4] & zone_low(line_lvl, ch));
         trip[ch] = !next_s.line_down[ch] && s.line_down[ch];
      end
      next_s.restart = trip;
      next_s.chan_en = next_s.run & ~next_s.faulted & ~next_s.line_down
                       & {8{ctl_lvl}};

      for (int k = 0; k < int'(ZONE_LINES); k++) begin
         next_s.line_oe[k] = 1'b0;
         next_s.line_oe[k+4] = 1'b0;
         for (int c = 0; c < int'(ZONE_CH); c++) begin
            next_s.line_oe[k] |= next_s.faulted[c] & next_s.prop[c*4+k];
            next_s.line_oe[k+4] |= next_s.faulted[c+4] & next_s.prop[(c+4)*4+k];
         end
      end

      // Clearing and a new event in one cycle: the event stays
      if (clr_status) begin
         next_s.status = 32'h0000_0000;
      end
      next_s.status = next_s.status | {trip, warn_i, uv_fault_i, ov_fault_i};
      next_s.alert_n = ~|(next_s.status & s.amask);
      next_s.pg = &(chan_good_i | ~s.pg_map);

      // Scale from the new code and range so level and range move on one edge
      prod = {12'h000, next_s.dac_code}
             * (next_s.ctrl[CTRL_DAC_HI] ? DAC_FS_HIGH_MV : DAC_FS_LOW_MV);
      next_s.dac_mv = 12'(prod / DAC_STEPS);
      // Polarity bit inverts the code for trim-pin converters
      next_s.dac_pin = next_s.ctrl[CTRL_DAC_POL] ? ~next_s.dac_code : next_s.dac_code;

      if (wd_lvl) begin
         next_s.wd_cnt = 16'h0000;
      end else if (!wd_hit) begin
         next_s.wd_cnt = s.wd_cnt + 16'h0001;
      end
      if (wd_hit) begin
         next_s = RST;
         next_s.wd_cnt = s.wd_cnt;
         next_s.ctl_prev = ctl_lvl;
         next_s.bias_prev = bias_lvl;
      end
   end

   always_comb begin
      unique case (req.addr)
         OFS_CTRL:   rdata = {28'h0, s.ctrl};
         OFS_VINEN:  rdata = {16'h0, s.uv_act, s.ov_act};
         OFS_PROP:   rdata = s.prop;
         OFS_RESP:   rdata = s.resp;
         OFS_AMASK:  rdata = s.amask;
         OFS_PGMAP:  rdata = {24'h0, s.pg_map};
         OFS_DAC:    rdata = {22'h0, s.dac_code};
         OFS_OPER:   rdata = {24'h0, s.run};
         OFS_STATUS: rdata = s.status;
         OFS_STATE:  rdata = {7'h0, s.vin_low, s.line_down, s.faulted, s.chan_en};
         default:    rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= RST;
      end else begin
         s <= next_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign zone_fault_line_o = 8'h00;
   assign zone_fault_line_oe_o = s.line_oe;
   assign chan_enable_o = s.chan_en;
   assign chan_restart_o = s.restart;
   assign input_enable_o = ~s.vin_low;
   assign alert_line_n_o = s.alert_n;
   assign power_good_output_o = s.pg;
   assign trim_dac_code_o = s.dac_pin;
   assign trim_dac_output_mv_o = s.dac_mv;
   assign dac_full_scale_range_o = s.ctrl[CTRL_DAC_HI];
   assign share_sync_en_o = s.ctrl[CTRL_SHARE_EN];

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!reset_n_i || wd_hit);

   property p_vinen_trip;
      (ov_fault_i[0] && s.ov_act[0]) || (uv_fault_i[2] && s.uv_act[2]) |=> !input_enable_o;
   endproperty
   a_vinen_trip: assert property (p_vinen_trip) else $error("input enable not pulled");

   property p_vinen_rel;
      (req.wr && req.addr == OFS_OPER && req.wdata[7:0] != 8'h00
       && ((ov_fault_i & s.ov_act) | (uv_fault_i & s.uv_act)) == 8'h00) |=> input_enable_o;
   endproperty
   a_vinen_rel: assert property (p_vinen_rel) else $error("input enable not released");

   property p_prop;
      s.faulted[0] && s.prop[0] |-> zone_fault_line_oe_o[0];
   endproperty
   a_prop: assert property (p_prop) else $error("faulted channel not propagated");

   property p_resp;
      !line_lvl[0] && s.resp[4] |=> !chan_enable_o[1] && s.line_down[1];
   endproperty
   a_resp: assert property (p_resp) else $error("channel kept on by low line");

   property p_restart;
      $fell(s.line_down[1]) |-> chan_restart_o[1] ##1 !chan_restart_o[1];
   endproperty
   a_restart: assert property (p_restart) else $error("no restart after release");

   property p_clear;
      req.wr && req.addr == OFS_CTRL && req.wdata[CTRL_CLR_FAULT] && ov_fault_i == 8'h00
      && uv_fault_i == 8'h00 && warn_i == 8'h00
      && (s.line_down & ~next_s.line_down) == 8'h00 |=> alert_line_n_o;
   endproperty
   a_clear: assert property (p_clear) else $error("alert held after clear");

   property p_alert;
      (warn_i[2] && s.amask[18]) |=> !alert_line_n_o;
   endproperty
   a_alert: assert property (p_alert) else $error("masked-in warning gave no alert");

   property p_pg;
      ((chan_good_i & s.pg_map) != s.pg_map) |=> !power_good_output_o;
   endproperty
   a_pg: assert property (p_pg) else $error("power good with mapped channel bad");

   property p_wd;
      @(posedge clk_i) disable iff (!reset_n_i)
      wd_hit |=> chan_enable_o == 8'h00 && s.run == 8'h00;
   endproperty
   a_wd: assert property (p_wd) else $error("watchdog reset ignored");

   property p_dac;
      trim_dac_output_mv_o <= (dac_full_scale_range_o ? DAC_FS_HIGH_MV : DAC_FS_LOW_MV);
   endproperty
   a_dac: assert property (p_dac) else $error("dac level above full scale");

   c_line_shut: cover property ($rose(s.line_down[0]));
   c_vinen:     cover property ($fell(input_enable_o) ##[1:1000] $rose(input_enable_o));
   c_restart:   cover property (|chan_restart_o);
endmodule

// file: hw/mfm_pkg.sv
// Constants, carrier types and register map of the multichannel fault manager.
// Assumes one 50 MHz system clock and an AHB-Lite register bus.
//
// What this block does
// - Output over/undervoltage fault pulls input enable low when its action bit is set.
// - Input enable stops pulling low once the device is commanded on again.
// - Eight channels form two fault zones of four, each with its own lines.
// - Per channel propagate bits pick zone lines pulled low while faulted off.
// - Per channel response bits pick zone lines; any selected low line shuts it.
// - A line-shut channel restarts when the faulted channel releases the line.
// - A line held low through a 10 us deglitch starts the off sequence.
// - Active-low alert asserts for a maskable set of faults and warnings.
// - Watchdog reset input held low for the minimum time resets the device.
// - Power good combines only the channels chosen by the channel map.
// - DAC has 1.38 V and 2.65 V full scale ranges scaling every code.
// - Clear faults empties the status register and releases the alert line.
// - Latched faults clear on control toggle, operation command or bias cycle.
package mfm_pkg;
   localparam int unsigned CLK_PERIOD_NS       = 20;
   localparam int unsigned FAULT_DEGLITCH_NS   = 10000;
   localparam int unsigned FAULT_DEGLITCH_CYC  =
      (FAULT_DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned RESET_PULSE_MIN_NS  = 20000;
   localparam int unsigned RESET_PULSE_MIN_CYC =
      (RESET_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned PIN_FILTER_CYC      = 1;

   localparam int unsigned NUM_CH    = 8;
   localparam int unsigned ZONE_CH   = 4;
   localparam int unsigned ZONE_LINES = 4;

   localparam logic [11:0] DAC_FS_LOW_MV  = 12'd1380;
   localparam logic [11:0] DAC_FS_HIGH_MV = 12'd2650;
   localparam logic [21:0] DAC_STEPS      = 22'd1023;

   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_VINEN  = 8'h04;
   localparam logic [7:0] OFS_PROP   = 8'h08;
   localparam logic [7:0] OFS_RESP   = 8'h0c;
   localparam logic [7:0] OFS_AMASK  = 8'h10;
   localparam logic [7:0] OFS_PGMAP  = 8'h14;
   localparam logic [7:0] OFS_DAC    = 8'h18;
   localparam logic [7:0] OFS_OPER   = 8'h1c;
   localparam logic [7:0] OFS_STATUS = 8'h20;
   localparam logic [7:0] OFS_STATE  = 8'h24;

   localparam int unsigned CTRL_DAC_POL   = 0;
   localparam int unsigned CTRL_DAC_HI    = 1;
   localparam int unsigned CTRL_CLR_FAULT = 2;
   localparam int unsigned CTRL_SHARE_EN  = 3;

   localparam logic [31:0] RST_PROP  = 32'h0000_0000;
   localparam logic [31:0] RST_RESP  = 32'h0000_0000;
   localparam logic [31:0] RST_AMASK = 32'hffff_ffff;

   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [7:0]  addr;
      logic [31:0] wdata;
   } mfm_regreq_t;
endpackage

// file: hw/mfm_deglitch.sv
// Two-flop synchroniser followed by a low-level persistence filter.
// Assumes an asynchronous pin input; a release passes after synchronising only.
`timescale 1ns/1ns
module mfm_deglitch
   import mfm_pkg::*;
#(
   parameter int unsigned CYCLES = 1
) (
   input  wire logic clk_i,
   input  wire logic reset_n_i,
   input  wire logic pin_i,
   output logic      level_o
);

   typedef struct packed {
      logic        s1;
      logic        s2;
      logic [15:0] cnt;
      logic        level;
   } mfm_dg_state_t;

   mfm_dg_state_t s, next_s;

   always_comb begin
      next_s = s;
      next_s.s1 = pin_i;
      next_s.s2 = s.s1;
      if (s.s2) begin
         next_s.cnt = 16'h0000;
         next_s.level = 1'b1;
      end else if (s.cnt >= 16'(CYCLES - 1)) begin
         // Only a low that lasted the full window reaches the logic
         next_s.level = 1'b0;
      end else begin
         next_s.cnt = s.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= '{s1: 1'b1, s2: 1'b1, cnt: 16'h0000, level: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign level_o = s.level;

   property p_dg_hold;
      @(posedge clk_i) disable iff (!reset_n_i)
      $fell(s.level) |-> $past(s.cnt) == 16'(CYCLES - 1) && !$past(s.s2);
   endproperty
   a_dg_hold: assert property (p_dg_hold) else $error("line fell before its window");
endmodule

// file: hw/mfm_ahb_if.sv
// AHB-Lite slave front end: writes complete with no wait, reads add one wait.
// Assumes a single slave whose hreadyout is the bus hready.
`timescale 1ns/1ns
module mfm_ahb_if
   import mfm_pkg::*;
(
   input  wire logic        clk_i,
   input  wire logic        reset_n_i,
   input  wire logic        hsel_i,
   input  wire logic [31:0] haddr_i,
   input  wire logic [1:0]  htrans_i,
   input  wire logic        hwrite_i,
   input  wire logic [2:0]  hsize_i,
   input  wire logic [31:0] hwdata_i,
   input  wire logic        hready_i,
   output logic [31:0]      hrdata_o,
   output logic             hreadyout_o,
   output logic             hresp_o,
   output mfm_pkg::mfm_regreq_t req_o,
   input  wire logic [31:0] rdata_i
);

   typedef enum logic [2:0] {
      AHB_IDLE = 3'b001,
      AHB_WR   = 3'b010,
      AHB_RD   = 3'b100
   } mfm_ahb_ph_t;

   typedef struct packed {
      mfm_ahb_ph_t ph;
      logic [7:0]  addr;
      logic [31:0] rdata;
      logic        ready;
   } mfm_ahb_state_t;

   mfm_ahb_state_t s, next_s;
   logic           take;

   always_comb begin
      next_s = s;
      next_s.ready = 1'b1;
      take = hsel_i && htrans_i[1] && hready_i && hsize_i == 3'b010;
      req_o = '{wr: s.ph == AHB_WR, rd: 1'b0, addr: s.addr, wdata: hwdata_i};
      unique case (s.ph)
         AHB_RD: begin
            // Register value is captured one cycle after the address phase
            req_o.rd = 1'b1;
            next_s.rdata = rdata_i;
            next_s.ph = AHB_IDLE;
         end
         AHB_WR, AHB_IDLE: begin
            next_s.ph = AHB_IDLE;
         end
         default: next_s.ph = AHB_IDLE;
      endcase
      if (take) begin
         next_s.addr = {haddr_i[7:2], 2'b00};
         next_s.ph = hwrite_i ? AHB_WR : AHB_RD;
         next_s.ready = hwrite_i;
      end
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= '{ph: AHB_IDLE, addr: 8'h00, rdata: 32'h0000_0000, ready: 1'b1};
      end else begin
         s <= next_s;
      end
   end

   assign hrdata_o = s.rdata;
   assign hreadyout_o = s.ready;
   assign hresp_o = 1'b0;

   property p_rd_wait;
      @(posedge clk_i) disable iff (!reset_n_i)
      (take && !hwrite_i) |=> !hreadyout_o ##1 hreadyout_o;
   endproperty
   a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
endmodule

// file: tb/mfm_peer.sv
// Far side of the zone fault lines: other managers or external drivers.
// Assumes every line has a pull-up and the design only ever pulls low.
`timescale 1ns/1ns
module mfm_peer (
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] pull_i,
   input  wire logic       tie_i,
   output logic [7:0]      line_o
);
   // Wired-AND: a low from any party is seen by all, idle lines float high;
   // tied mode shorts every line into one net
   assign line_o = tie_i ? {8{~|(oe_i | pull_i)}} : ~(oe_i | pull_i);
endmodule

// file: tb/mfm_top_tb.sv
// Self-checking bench for the fault manager top level.
// Assumes the AHB-Lite slave is the only one on the bus and lines are pulled up.
`timescale 1ns/1ns
module mfm_top_tb
   import mfm_pkg::*;
;
   logic        clk_i = 1'h0;
   logic        reset_n_i = 1'h0;
   logic [31:0] haddr = '0, hwdata = '0, hrdata;
   logic [1:0]  htrans = '0;
   logic        hwrite = 1'h0, hrdy, inen, alert_n, pg, fsr, share;
   logic        wd_n = 1'h1, tie = 1'h0;
   logic [7:0]  ov = '0, warn = '0, good = '0, pull = '0;
   logic [7:0]  line, oe, en, rst;
   logic [9:0]  code;
   logic [11:0] mv;
   int          err_total = 0;
   int          check_count = 0;
   ////////////////////////////////////////////////////////////////////////
   mfm_peer u_peer (.oe_i(oe), .pull_i(pull), .tie_i(tie), .line_o(line));
   mfm_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .hsel_i(1'h1),
      .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
      .hresp_o(), .ov_fault_i(ov), .uv_fault_i(8'h00), .warn_i(warn),
      .chan_good_i(good), .control_i(1'h1), .bias_ok_i(1'h1),
      .watchdog_reset_input_n_i(wd_n), .zone_fault_line_i(line),
      .zone_fault_line_o(), .zone_fault_line_oe_o(oe), .chan_enable_o(en),
      .chan_restart_o(rst), .input_enable_o(inen), .alert_line_n_o(alert_n),
      .power_good_output_o(pg), .trim_dac_code_o(code),
      .trim_dac_output_mv_o(mv), .dac_full_scale_range_o(fsr),
      .share_sync_en_o(share));
   ////////////////////////////////////////////////////////////////////////
   task automatic conclude;
      if (err_total == 0 && check_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Master holds each phase until it samples hready high
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      haddr <= 32'(a); htrans <= 2'h2; hwrite <= 1'h1;
      do @(posedge clk_i); while (hrdy !== 1'h1);
      htrans <= 2'h0; hwdata <= d;
      do @(posedge clk_i); while (hrdy !== 1'h1);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk_i);
      haddr <= 32'(a); htrans <= 2'h2; hwrite <= 1'h0;
      do @(posedge clk_i); while (hrdy !== 1'h1);
      htrans <= 2'h0;
      do @(posedge clk_i); while (hrdy !== 1'h1);
      d = hrdata;
   endtask
   task automatic wait_en(input int b, input logic v, output int n);
      n = 0;
      while (en[b] !== v && n < 2000) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   task automatic wait_rst(input int b);
      int n;
      n = 0;
      while (rst[b] !== 1'h1 && n < 50) begin
         @(negedge clk_i);
         n++;
      end
      chk(32'(rst[b]), 32'h1);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [31:0] d;
      rd(OFS_PROP, d);
      chk(d, RST_PROP);
      rd(OFS_AMASK, d);
      chk(d, RST_AMASK);
      rd(8'h40, d);
      chk(d, 32'h0);
      chk(32'(inen), 32'h1);
   endtask
   task automatic t_alert;
      logic [31:0] d;
      @(posedge clk_i) warn <= 8'h04;
      @(posedge clk_i) warn <= 8'h00;
      repeat (3) @(negedge clk_i);
      chk(32'(alert_n), 32'h0);
      rd(OFS_STATUS, d);
      chk(d, 32'h0004_0000);
      wr(OFS_CTRL, 32'h4);
      repeat (2) @(negedge clk_i);
      chk(32'(alert_n), 32'h1);
      rd(OFS_STATUS, d);
      chk(d, 32'h0);
   endtask
   task automatic t_pg;
      wr(OFS_PGMAP, 32'h3);
      @(posedge clk_i) good <= 8'h03;
      repeat (3) @(negedge clk_i);
      chk(32'(pg), 32'h1);
      @(posedge clk_i) good <= 8'hfe;
      repeat (3) @(negedge clk_i);
      chk(32'(pg), 32'h0);
   endtask
   task automatic t_dac;
      wr(OFS_CTRL, 32'ha);
      wr(OFS_DAC, 32'h3ff);
      repeat (3) @(negedge clk_i);
      chk(32'(mv), 32'(DAC_FS_HIGH_MV));
      chk({30'h0, fsr, share}, 32'h3);
      wr(OFS_CTRL, 32'h0);
      wr(OFS_DAC, 32'h200);
      repeat (3) @(negedge clk_i);
      chk(32'(mv), 32'd690);
      chk(32'(code), 32'h200);
      wr(OFS_CTRL, 32'h1);
      repeat (3) @(negedge clk_i);
      chk(32'(code), 32'h1ff);
   endtask
   // Channel 0 faults onto zone 0 line 0; channel 1 listens to it
   task automatic t_prop;
      int n;
      wr(OFS_VINEN, 32'h1);
      wr(OFS_PROP, 32'h1);
      wr(OFS_RESP, 32'h0001_0010);
      wr(OFS_OPER, 32'hff);
      wait_en(1, 1'h1, n);
      @(posedge clk_i) ov <= 8'h01;
      wait_en(0, 1'h0, n);
      @(negedge clk_i);
      chk(32'(oe), 32'h1);
      chk(32'(inen), 32'h0);
      wait_en(1, 1'h0, n);
      chk(32'(n > 490 && n < 515), 32'h1);
      chk(32'(en[5:4]), 32'h3);
      @(posedge clk_i) ov <= 8'h00;
      wr(OFS_OPER, 32'hff);
      wait_rst(1);
      @(negedge clk_i);
      chk(32'(inen), 32'h1);
      chk(32'(oe), 32'h0);
   endtask
   // External driver on zone 1 line 0: a short glitch, then a real request
   task automatic t_ext;
      int n;
      @(posedge clk_i) pull <= 8'h10;
      repeat (300) @(posedge clk_i);
      pull <= 8'h00;
      repeat (10) @(negedge clk_i);
      chk(32'(en[4]), 32'h1);
      @(posedge clk_i) pull <= 8'h10;
      wait_en(4, 1'h0, n);
      chk(32'(n > 495 && n < 515), 32'h1);
      chk(32'(en[5]), 32'h1);
      @(posedge clk_i) pull <= 8'h00;
      wait_rst(4);
   endtask
   // All lines tied together: one fault anywhere takes every channel down
   task automatic t_tie;
      int n;
      @(posedge clk_i) tie <= 1'h1;
      wr(OFS_PROP, 32'h1111_1111);
      wr(OFS_RESP, 32'hffff_ffff);
      @(posedge clk_i) ov <= 8'h40;
      @(posedge clk_i) ov <= 8'h00;
      wait_en(0, 1'h0, n);
      chk(32'(n > 495 && n < 515), 32'h1);
      chk(32'(en), 32'h0);
      chk(32'(inen), 32'h1);
      wr(OFS_OPER, 32'hff);
      wait_rst(0);
   endtask
   // Watchdog pin held low: nothing before the minimum time, full reset after it
   task automatic t_wd;
      logic [31:0] d;
      @(posedge clk_i) wd_n <= 1'h0;
      repeat (RESET_PULSE_MIN_CYC - 10) @(negedge clk_i);
      chk(32'(en), 32'hff);
      repeat (20) @(negedge clk_i);
      chk(32'(en), 32'h0);
      rd(OFS_PGMAP, d);
      chk(d, 32'h0);
      @(posedge clk_i) wd_n <= 1'h1;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      forever #10 clk_i = ~clk_i;
   end
   initial begin
      repeat (20) @(posedge clk_i);
      reset_n_i <= 1'h1;
      t_regs;
      t_alert;
      t_pg;
      t_dac;
      t_prop;
      t_ext;
      t_tie;
      t_wd;
      conclude;
   end
   // Whole sequence needs about 3000 cycles
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      conclude;
   end
endmodule
